// *** include/isf_defs.vh ***
`ifndef ISF_DEFS_VH
`define ISF_DEFS_VH

// ----------------------------------------------------------------
// Register word addresses (byte address bits 4:2)
// ----------------------------------------------------------------
`define ISF_ADR_STATUS   3'h0
`define ISF_ADR_CTRL     3'h1
`define ISF_ADR_IRQ_STAT 3'h2
`define ISF_ADR_IRQ_EN   3'h3
`define ISF_ADR_IRQ_CLR  3'h4
`define ISF_ADR_LSB      2
`define ISF_ADR_MSB      4

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define ISF_ST_ACK_RESULT 15
`define ISF_ST_MTX_ACTIVE 14
`define ISF_ST_ACK_WINDOW 13
`define ISF_ST_COLLISION  10

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define ISF_CT_ENABLE     0
`define ISF_CT_SLAVE      1
`define ISF_CT_MTX_START  2

// ----------------------------------------------------------------
// Interrupt event bit positions and widths
// ----------------------------------------------------------------
`define ISF_EV_COLLISION  0
`define ISF_EV_BYTE_DONE  1
`define ISF_EV_NACK       2
`define ISF_EV_W          3

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define ISF_BITS_PER_BYTE 4'h8
`define ISF_ACK_BIT       4'h9
`define ISF_CTRL_RESET    16'h0000

`endif

// *** verilog/isf_pin_sync.v ***
`timescale 1ns/1ps
// Two-stage synchroniser with edge detection on the settled value
module isf_pin_sync (
  input  wire clk_i,
  input  wire rst_i,
  input  wire pin_i,
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  reg meta_q;
  reg sync_q;
  reg last_q;

  // ----------------------------------------------------------------
  // Sync chain; only sync_q and last_q feed logic
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~last_q;
  assign fall_o  = ~sync_q & last_q;
endmodule

// *** verilog/isf_status_flags.v ***
`timescale 1ns/1ps
// Function
// - ack result updated every byte, 1 = nack
// - ack window flag meaningful in slave only
// - slave: set window on eighth scl fall
// - clear window on ninth scl rise
// - collision flag set on transmit collision
// - collision cleared while disabled or by write
`include "isf_defs.vh"
module isf_status_flags (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire        wb_err_o,
  input  wire        scl_i,
  input  wire        sda_i,
  input  wire        sda_drive_i,
  input  wire        start_i,
  output wire        irq_o
);
  wire        scl_lvl;
  wire        scl_rise;
  wire        scl_fall;
  wire        sda_lvl;
  wire        start_rise;
  wire        drv_lvl;
  reg  [15:0] ctrl_q;
  reg         ack_result_flag_q;
  reg         master_transmit_active_q;
  reg         ack_window_flag_q;
  reg         collision_flag_q;
  reg  [3:0]  fall_cnt_q;
  reg  [3:0]  rise_cnt_q;
  reg  [`ISF_EV_W-1:0] irq_stat_q;
  reg  [`ISF_EV_W-1:0] irq_en_q;
  reg  [`ISF_EV_W-1:0] ev;
  wire        module_enable_bit;
  wire        slave_mode;
  wire        req;
  wire        wr;
  wire [2:0]  widx;
  wire        valid_adr;
  wire [15:0] status_word;
  wire        ninth_rise;
  wire        eighth_fall;
  wire        ninth_fall;
  wire        collide_ev;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  isf_pin_sync u_scl (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (scl_i),
    .level_o (scl_lvl),
    .rise_o  (scl_rise),
    .fall_o  (scl_fall)
  );
  isf_pin_sync u_sda (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (sda_i),
    .level_o (sda_lvl),
    .rise_o  (),
    .fall_o  ()
  );
  isf_pin_sync u_start (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (start_i),
    .level_o (),
    .rise_o  (start_rise),
    .fall_o  ()
  );
  isf_pin_sync u_drv (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (sda_drive_i),
    .level_o (drv_lvl),
    .rise_o  (),
    .fall_o  ()
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Registers inside the mapped window
  function is_mapped;
    input [2:0] idx;
    begin
      is_mapped = (idx <= `ISF_ADR_IRQ_CLR);
    end
  endfunction

  // Bus strobes, control bits and serial edge positions
  assign req               = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign widx              = wb_adr_i[`ISF_ADR_MSB:`ISF_ADR_LSB];
  assign valid_adr         = is_mapped(widx) & ~|wb_adr_i[31:(`ISF_ADR_MSB+1)];
  assign wr                = req & wb_we_i & valid_adr & wb_sel_i[0];
  assign wb_err_o          = 1'b0;
  assign module_enable_bit = ctrl_q[`ISF_CT_ENABLE];
  assign slave_mode        = ctrl_q[`ISF_CT_SLAVE];
  assign ninth_rise        = scl_rise & (rise_cnt_q == `ISF_BITS_PER_BYTE);
  assign eighth_fall       = scl_fall & (rise_cnt_q == `ISF_BITS_PER_BYTE);
  assign ninth_fall        = scl_fall & (rise_cnt_q == 4'h0) & (fall_cnt_q == `ISF_BITS_PER_BYTE);
  assign collide_ev        = module_enable_bit & drv_lvl & scl_rise & ~sda_lvl;
  assign irq_o             = |(irq_stat_q & irq_en_q);

  // Status word as software reads it
  assign status_word = {ack_result_flag_q, master_transmit_active_q,
                        ack_window_flag_q, 2'b00, collision_flag_q, 10'h000};

  // ----------------------------------------------------------------
  // Control register and bus answer; ack one cycle after request
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q   <= `ISF_CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      irq_en_q <= {`ISF_EV_W{1'b0}};
    end else begin
      wb_ack_o <= req;
      if (wr && widx == `ISF_ADR_CTRL) begin
        ctrl_q[`ISF_CT_ENABLE] <= wb_dat_i[`ISF_CT_ENABLE];
        ctrl_q[`ISF_CT_SLAVE]  <= wb_dat_i[`ISF_CT_SLAVE];
      end
      if (wr && widx == `ISF_ADR_IRQ_EN)
        irq_en_q <= wb_dat_i[`ISF_EV_W-1:0];
      if (req && !wb_we_i) begin
        if (!valid_adr) begin
          wb_dat_o <= 32'h00000000;                      // Refused address reads zero
        end else begin
          case (widx)
            `ISF_ADR_STATUS:   wb_dat_o <= {16'h0000, status_word};
            `ISF_ADR_CTRL:     wb_dat_o <= {16'h0000, ctrl_q};
            `ISF_ADR_IRQ_STAT: wb_dat_o <= {{(32-`ISF_EV_W){1'b0}}, irq_stat_q};
            `ISF_ADR_IRQ_EN:   wb_dat_o <= {{(32-`ISF_EV_W){1'b0}}, irq_en_q};
            default:           wb_dat_o <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial clock rise count within a byte; fall count keeps the rise count at the last fall
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i || !module_enable_bit || start_rise) begin
      fall_cnt_q <= 4'h0;
      rise_cnt_q <= 4'h0;
    end else begin
      if (scl_fall)
        fall_cnt_q <= rise_cnt_q;                        // Fall right after start counts as none
      if (scl_rise)
        rise_cnt_q <= (rise_cnt_q == `ISF_BITS_PER_BYTE) ? 4'h0 : rise_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_result_flag_q        <= 1'b0;
      master_transmit_active_q <= 1'b0;
      ack_window_flag_q        <= 1'b0;
      collision_flag_q         <= 1'b0;
    end else begin
      if (ninth_rise)
        ack_result_flag_q <= sda_lvl;
      if (!module_enable_bit || slave_mode)
        master_transmit_active_q <= 1'b0;
      else if (start_rise)
        master_transmit_active_q <= 1'b1;
      else if (ninth_fall)
        master_transmit_active_q <= 1'b0;
      if (!module_enable_bit || !slave_mode)
        ack_window_flag_q <= 1'b0;
      else if (eighth_fall)
        ack_window_flag_q <= 1'b1;
      else if (ninth_rise)
        ack_window_flag_q <= 1'b0;
      if (!module_enable_bit)
        collision_flag_q <= 1'b0;
      else if (collide_ev)
        collision_flag_q <= 1'b1;
      else if (wr && widx == `ISF_ADR_STATUS && !wb_dat_i[`ISF_ST_COLLISION])
        collision_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status: set wins over clear
  // ----------------------------------------------------------------
  // Event strobes; counters stay cleared while disabled
  always @* begin
    ev = {`ISF_EV_W{1'b0}};
    ev[`ISF_EV_COLLISION] = collide_ev;
    ev[`ISF_EV_BYTE_DONE] = module_enable_bit & ninth_rise;
    ev[`ISF_EV_NACK]      = module_enable_bit & ninth_rise & sda_lvl;
  end

  always @(posedge clk_i) begin
    if (rst_i)
      irq_stat_q <= {`ISF_EV_W{1'b0}};
    else if (wr && widx == `ISF_ADR_IRQ_CLR)
      irq_stat_q <= (irq_stat_q & ~wb_dat_i[`ISF_EV_W-1:0]) | ev;
    else
      irq_stat_q <= irq_stat_q | ev;
  end
endmodule

// *** sim/isf_bus_model.sv ***
`timescale 1ns/1ps
module isf_bus_model (
  output logic scl_o,
  output logic sda_o
);
  // Idle bus: both lines at the pull-up level
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Clock n bits of v out, MSB first, 125 ns a bit; data moves only while scl is low
  task automatic bits(input int n, input int v);
    for (int i = n - 1; i >= 0; i--) begin
      scl_o = 1'b0;
      #31.25 sda_o = v[i];
      #31.25 scl_o = 1'b1;
      #62.5 scl_o = 1'b0;
    end
    #40 sda_o = 1'b1;  // Released line goes to its pull-up level
  endtask
  // Stop condition, then the line floats back to its pull-up
  task automatic stop();
    #31.25 sda_o = 1'b0;
    #31.25 scl_o = 1'b1;
    #31.25 sda_o = 1'b1;
  endtask
endmodule

// *** sim/isf_status_flags_chk.sv ***
`timescale 1ns/1ps
module isf_status_flags_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        wb_err_o,
  input wire        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus request seen by the slave
  wire req = wb_cyc_i && wb_stb_i;
  ack_next_a: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (!req |=> !wb_ack_o) else $error("ack without request");
  err_low_a: assert property (!wb_err_o) else $error("err raised");
  rst_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o) else $error("busy after reset");
  unmap_zero_a: assert property (req && !wb_we_i && !wb_ack_o && wb_adr_i > 32'h10 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper half set");
  dat_hold_a: assert property (!(req && !wb_we_i) |=> $stable(wb_dat_o)) else $error("read data moved");
  // Main traffic kinds
  rd_c: cover property (req && !wb_we_i && wb_ack_o);
  wr_c: cover property (req && wb_we_i && wb_ack_o);
  irq_c: cover property ($rose(irq_o));
endmodule
bind isf_status_flags isf_status_flags_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .irq_o(irq_o));

// *** sim/isf_status_flags_tb.sv ***
`timescale 1ns/1ps
module isf_status_flags_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic        drv = 1'b0;
  logic        start = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q;
  wire  [31:0] rdat;
  wire         ack;
  wire         irq;
  wire         scl;
  wire         sda;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          d;
  always #5 clk_i = ~clk_i;
  isf_status_flags u_isf_status_flags (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(), .scl_i(scl), .sda_i(sda), .sda_drive_i(drv), .start_i(start), .irq_o(irq));
  isf_bus_model u_isf_bus_model (.scl_o(scl), .sda_o(sda));
  // Expected status word from the flag model
  function automatic int fl(int a, int t, int w, int c);
    return a << 15 | t << 14 | w << 13 | c << 10;
  endfunction
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic single cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] v);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    if (ack !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic rd(input logic [31:0] a, input string nm, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  // Start pulse, then n bits from the far side
  task automatic go(input int n, input int v);
    @(posedge clk_i);
    start <= 1'b1;
    repeat (4) @(posedge clk_i);
    start <= 1'b0;
    repeat (4) @(posedge clk_i);
    u_isf_bus_model.bits(n, v);
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h5232FBFB));
    d = $urandom & 32'hFF;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b1, 32'h44, 32'hFFFF);
    for (int a = 0; a < 4; a++) rd(a * 4, "reset", 32'h0);
    rd(32'h40, "unmapped", 32'h0);
    $display("test reset done");
    wb(1'b1, 32'h4, 32'h3);
    go(8, d);
    rd(32'h0, "window", fl(0, 0, 1, 0));
    u_isf_bus_model.bits(1, 1);
    rd(32'h0, "nack", fl(1, 0, 0, 0));
    rd(32'h8, "events", 32'h6);
    u_isf_bus_model.stop();
    go(9, d << 1);
    rd(32'h0, "acked", fl(0, 0, 0, 0));
    u_isf_bus_model.stop();
    $display("test slave done");
    wb(1'b1, 32'h4, 32'h1);
    go(4, d >> 4);
    rd(32'h0, "tx", fl(0, 1, 0, 0));
    u_isf_bus_model.bits(4, d);
    rd(32'h0, "tx8", fl(0, 1, 0, 0));
    u_isf_bus_model.bits(1, 0);
    rd(32'h0, "txend", fl(0, 0, 0, 0));
    u_isf_bus_model.stop();
    $display("test master done");
    wb(1'b1, 32'h10, 32'h7);
    wb(1'b1, 32'hC, 32'h1);
    drv <= 1'b1;
    go(1, 0);
    rd(32'h0, "collide", fl(0, 1, 0, 1));
    chk("irq", irq, 32'h1);
    rd(32'h40, "unmapped busy", 32'h0);
    wb(1'b1, 32'hC, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("masked", irq, 32'h0);
    wb(1'b1, 32'h0, 32'h0);
    rd(32'h0, "swclear", fl(0, 1, 0, 0));
    wb(1'b1, 32'h10, 32'h1);
    rd(32'h8, "evclear", 32'h0);
    u_isf_bus_model.bits(1, 0);
    wb(1'b1, 32'h4, 32'h0);
    rd(32'h0, "disabled", 32'h0);
    drv <= 1'b0;
    $display("test collision done");
    wb(1'b1, 32'h4, 32'h3);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(32'h4, "rst ctrl", 32'h0);
    rd(32'h8, "rst events", 32'h0);
    rd(32'h0, "rst status", 32'h0);
    $display("test midreset done");
    test_done();
  end
endmodule
